// ===== hw/gpio_level_sense_latch.sv
// level sense pin port: config, outputs, sense, latch and detect
`timescale 1ns/1ns
module gpio_level_sense_latch (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic warm_rst_i,
  input wire logic ce_i,
  input wire logic sleep_i,
  input wire logic [11:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [31:0] pin_i,
  output logic [31:0] pin_o,
  output logic [31:0] pin_oe_o,
  output logic [31:0] high_drive_o,
  output logic [31:0] pull_up_o,
  output logic [31:0] pull_down_o,
  output logic [31:0] in_buf_en_o,
  input wire logic [31:0] periph_sel_i,
  input wire logic [31:0] periph_out_i,
  input wire logic [31:0] periph_oe_i,
  output logic [31:0] periph_in_o,
  input wire logic [31:0] te_set_i,
  input wire logic [31:0] te_clr_i,
  output logic [31:0] per_pin_detect_o,
  output logic latched_detect_o,
  output logic port_detect_o,
  output logic port_event_o
);
  // checks below run on the one clock, off during either reset
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i | warm_rst_i);

  // warm reset clears working state but not the config words
  logic any_rst;
  assign any_rst = rst_i | warm_rst_i;

  // ---- bus slave ----
  gpio_pkg::bus_state_t state; // request sequencing
  gpio_pkg::bus_state_t next_state;
  logic req; // master holds a cycle open
  logic [11:0] wa; // word-aligned address
  logic [4:0] idx; // pin index of a config access
  logic [31:0] wm; // byte enables as bits
  logic [31:0] wd; // enabled write bits
  logic wr; // write takes effect this edge
  logic hit_out, hit_outset, hit_outclr, hit_in, hit_dir, hit_dirset; // one per register word
  logic hit_dirclr, hit_latch, hit_mode, hit_cfg, hit_dirany, hit_outany;
  assign req = cyc_i & stb_i;
  assign wa = {adr_i[11:2], 2'b00};
  assign idx = adr_i[6:2];
  assign wm = gpio_pkg::byte_mask(sel_i);
  assign wd = dat_i & wm;
  assign wr = (state == gpio_pkg::BUS_ACK) & req & we_i;
  // address decode
  assign hit_out = wa == gpio_pkg::OFF_OUT;
  assign hit_outset = wa == gpio_pkg::OFF_OUTSET;
  assign hit_outclr = wa == gpio_pkg::OFF_OUTCLR;
  assign hit_in = wa == gpio_pkg::OFF_IN;
  assign hit_dir = wa == gpio_pkg::OFF_DIR;
  assign hit_dirset = wa == gpio_pkg::OFF_DIRSET;
  assign hit_dirclr = wa == gpio_pkg::OFF_DIRCLR;
  assign hit_latch = wa == gpio_pkg::OFF_LATCH;
  assign hit_mode = wa == gpio_pkg::OFF_MODE;
  assign hit_cfg = (wa >= gpio_pkg::OFF_CFG_BASE) & (wa <= gpio_pkg::OFF_CFG_LAST);
  assign hit_dirany = hit_dir | hit_dirset | hit_dirclr;
  assign hit_outany = hit_out | hit_outset | hit_outclr;

  // idle -> fetch -> ack; the fetch cycle lets config reads settle
  always_comb begin
    case (state)
      gpio_pkg::BUS_IDLE: next_state = req ? gpio_pkg::BUS_FETCH : gpio_pkg::BUS_IDLE;
      gpio_pkg::BUS_FETCH: next_state = gpio_pkg::BUS_ACK;
      gpio_pkg::BUS_ACK: next_state = gpio_pkg::BUS_IDLE;
      default: next_state = gpio_pkg::BUS_IDLE;
    endcase
  end
  // ack stands for exactly one cycle per request
  assign ack_o = (state == gpio_pkg::BUS_ACK) & req;

  // state register
  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      state <= gpio_pkg::BUS_IDLE;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  // ---- pin input path ----
  logic [31:0] pin_sync_q; // filtered pin levels
  logic [31:0] in_v; // levels seen past the input buffer
  logic [31:0] inbuf_on; // input buffer connected
  logic [31:0][31:0] cfg; // every pin_config word
  logic [31:0] cfg_rdata; // registered config read
  // asynchronous pins are synchronised first
  pin_sync u_sync (
    .clk_i(clk_i),
    .rst_i(any_rst),
    .ce_i(ce_i),
    .async_i(pin_i),
    .sync_o(pin_sync_q)
  );
  // a disconnected buffer reads zero and cannot sense
  assign in_v = pin_sync_q & inbuf_on;

  // ---- configuration store ----
  logic cfg_we;
  assign cfg_we = wr & hit_cfg;
  // one retained word per pin
  pin_config_store u_cfg (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .we_i(cfg_we),
    .widx_i(idx),
    .wdata_i(dat_i),
    .wmask_i(wm),
    .ridx_i(idx),
    .rdata_o(cfg_rdata),
    .cfg_o(cfg)
  );

  // ---- output and direction registers ----
  logic [31:0] out; // software output levels
  logic [31:0] dir; // direction, shared with config bit 0
  logic [31:0] out_sw;
  logic [31:0] next_out;
  logic [31:0] dir_sw;
  logic [31:0] cfg_dir_m; // config write touching one dir bit
  logic [31:0] next_dir;
  // software writes, set and clear forms
  assign out_sw = !(wr & hit_outany) ? out :
                  hit_out ? ((out & ~wm) | wd) :
                  hit_outset ? (out | wd) : (out & ~wd);
  // task events drive outputs after software, set winning
  assign next_out = (out_sw & ~te_clr_i) | te_set_i;
  assign dir_sw = !(wr & hit_dirany) ? dir :
                  hit_dir ? ((dir & ~wm) | wd) :
                  hit_dirset ? (dir | wd) : (dir & ~wd);
  // config write lands in the same direction flop
  assign cfg_dir_m = (cfg_we & sel_i[0]) ? (32'h0000_0001 << idx) : 32'h0000_0000;
  assign next_dir = (dir_sw & ~cfg_dir_m) | ({32{dat_i[gpio_pkg::CFG_DIR_POS]}} & cfg_dir_m);

  // out is working state; dir belongs to the retained config
  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      out <= gpio_pkg::PORT_RESET;
    end else if (ce_i) begin
      out <= next_out;
    end
  end
  // direction only cleared at power-on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir <= gpio_pkg::PORT_RESET;
    end else if (ce_i) begin
      dir <= next_dir;
    end
  end
  // ---- per pin decode ----
  logic [31:0] next_pin, next_oe, next_hi, next_pu, next_pd; // pad controls ahead of their flops
  logic [31:0] hit; // sense match per pin
  logic [31:0] sense_en; // sense field not off
  for (genvar n = 0; n < gpio_pkg::NPINS; n++) begin : g_pin
    logic [1:0] dc; // {enable, strong}
    logic take; // peripheral owns the pin
    logic [1:0] sense;
    logic [1:0] pull;
    assign sense = cfg[n][gpio_pkg::CFG_SENSE_POS +: 2];
    assign pull = cfg[n][gpio_pkg::CFG_PULL_POS +: 2];
    // drive mode decides whether a level is driven at all
    assign dc = gpio_pkg::drive_ctl(cfg[n][gpio_pkg::CFG_DRIVE_POS +: 3], out[n]);
    // peripherals are powered down while asleep
    assign take = periph_sel_i[n] & ~sleep_i;
    // peripheral overrides level, enable and drive strength; pulls still follow the config
    assign next_pin[n] = take ? periph_out_i[n] : out[n];
    assign next_oe[n] = take ? periph_oe_i[n] : (dir[n] & dc[1]);
    assign next_hi[n] = ~take & dir[n] & dc[0];
    assign next_pu[n] = pull == gpio_pkg::PULL_UP;
    assign next_pd[n] = pull == gpio_pkg::PULL_DOWN;
    // field 0 connects the buffer, 1 cuts it off
    assign inbuf_on[n] = cfg[n][gpio_pkg::CFG_INBUF_POS] == gpio_pkg::INBUF_CONNECT;
    // high or low level match, code 0 gives none
    // gated by the buffer too: a cut-off pin reads 0 and must not match low
    assign hit[n] = inbuf_on[n] & gpio_pkg::sense_hit(sense, in_v[n]);
    assign sense_en[n] = sense != gpio_pkg::SENSE_OFF;
  end

  // pad controls from flops so the pins never glitch
  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      pin_o <= gpio_pkg::PORT_RESET;
      pin_oe_o <= gpio_pkg::PORT_RESET;
      high_drive_o <= gpio_pkg::PORT_RESET;
    end else if (ce_i) begin
      pin_o <= next_pin;
      pin_oe_o <= next_oe;
      high_drive_o <= next_hi;
    end
  end
  // pulls, buffer enable and the input seen by peripherals
  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      pull_up_o <= gpio_pkg::PORT_RESET;
      pull_down_o <= gpio_pkg::PORT_RESET;
      in_buf_en_o <= gpio_pkg::PORT_RESET;
      periph_in_o <= gpio_pkg::PORT_RESET;
    end else if (ce_i) begin
      pull_up_o <= next_pu;
      pull_down_o <= next_pd;
      in_buf_en_o <= inbuf_on;
      periph_in_o <= in_v;
    end
  end
  // ---- sense, latch and detect ----
  logic [31:0] det; // per pin detect
  logic [31:0] det_q; // previous detect, for edges
  logic [31:0] latch; // sticky sense flags
  logic [31:0] latch_clr; // clear request from software
  logic [31:0] next_latch;
  logic wr_latch; // latch write this edge
  logic mode; // detect source select
  logic ldet; // latched detect
  logic next_ldet;
  logic next_port;
  assign wr_latch = wr & hit_latch;
  assign latch_clr = wr_latch ? wd : 32'h0000_0000;
  // clear is refused while that pin still detects
  // a new rise wins over a clear in the same cycle
  assign next_latch = (latch & ~(latch_clr & ~det)) | (det & ~det_q);
  // high with any flag; dropped one cycle by a clear so it rises again
  assign next_ldet = (|next_latch) & ~wr_latch;
  // combined pin detects by default, latched detect when selected
  assign next_port = (mode == gpio_pkg::MODE_LATCHED) ? ldet : |det;

  // detect follows the sense match; sleep_i plays no part
  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      det <= gpio_pkg::PORT_RESET;
      det_q <= gpio_pkg::PORT_RESET;
    end else if (ce_i) begin
      det <= hit;
      det_q <= det;
    end
  end
  // flags stay set whatever the mode
  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      latch <= gpio_pkg::PORT_RESET;
      ldet <= 1'b0;
    end else if (ce_i) begin
      latch <= next_latch;
      ldet <= next_ldet;
    end
  end
  // source select resets to the combined form
  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      mode <= gpio_pkg::MODE_COMBINED;
    end else if (ce_i && wr && hit_mode && sel_i[0]) begin
      mode <= dat_i[0];
    end
  end
  // port detect and its rising-edge event
  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      port_detect_o <= 1'b0;
      port_event_o <= 1'b0;
    end else if (ce_i) begin
      port_detect_o <= next_port;
      port_event_o <= next_port & ~port_detect_o;
    end
  end
  assign per_pin_detect_o = det;
  assign latched_detect_o = ldet;
  // ---- read data ----
  logic [31:0] rd_word;
  // unmapped addresses read zero
  assign rd_word = hit_outany ? out :
                   hit_in ? in_v :
                   hit_dirany ? dir :
                   hit_latch ? latch :
                   hit_mode ? {31'h0000_0000, mode} :
                   hit_cfg ? (cfg_rdata | {31'h0000_0000, dir[idx]}) : 32'h0000_0000;
  // captured in the fetch cycle, held through ack
  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      dat_o <= 32'h0000_0000;
    end else if (ce_i && state == gpio_pkg::BUS_FETCH) begin
      dat_o <= rd_word;
    end
  end
  // ---- checks ----
  // the cycle right after a reset edge is left out: its sampled state predates the clear
  logic [31:0] rise;
  assign rise = det & ~det_q;
  property p_rise_sets;
    ce_i && !any_rst && rise != 32'h0000_0000 |=> (latch & $past(rise)) == $past(rise);
  endproperty
  a_rise_sets: assert property (p_rise_sets) else $error("detect rise did not set latch");
  property p_clear_blocked;
    ce_i && wr_latch |=> (latch & $past(latch & det)) == $past(latch & det);
  endproperty
  a_clear_blocked: assert property (p_clear_blocked) else $error("latch cleared while detect high");
  property p_only_write_clears;
    ce_i && !any_rst && !wr_latch |=> ($past(latch) & ~latch) == 32'h0000_0000;
  endproperty
  a_only_write_clears: assert property (p_only_write_clears) else $error("latch bit lost without write");
  property p_ldet_follows;
    ce_i && !any_rst && !wr_latch && latch != 32'h0000_0000 |=> ldet;
  endproperty
  a_ldet_follows: assert property (p_ldet_follows) else $error("latched detect low with flags set");
  sequence s_clear;
    ce_i && wr_latch;
  endsequence
  sequence s_left;
    ce_i && !wr_latch && latch != 32'h0000_0000;
  endsequence
  property p_rearm;
    s_clear ##1 s_left |-> !ldet ##1 ldet;
  endproperty
  a_rearm: assert property (p_rearm) else $error("no new latched detect edge");
  property p_port_source;
    ce_i && !any_rst && mode == gpio_pkg::MODE_COMBINED |=> port_detect_o == ($past(det) != 32'h0000_0000);
  endproperty
  a_port_source: assert property (p_port_source) else $error("port detect not combined");
  property p_event_edge;
    port_event_o && $past(ce_i) |-> port_detect_o && !$past(port_detect_o);
  endproperty
  a_event_edge: assert property (p_event_edge) else $error("port event without rise");
  property p_buf_blocks;
    ce_i && !any_rst |=> (det & ~$past(inbuf_on)) == 32'h0000_0000;
  endproperty
  a_buf_blocks: assert property (p_buf_blocks) else $error("disconnected pin detected high");
endmodule

// ===== hw/gpio_pkg.sv
// shared constants, states and helpers of the level sense pin port
package gpio_pkg;
  // port width
  localparam int NPINS = 32;
  // register byte offsets
  localparam logic [11:0] OFF_OUT = 12'h504;
  localparam logic [11:0] OFF_OUTSET = 12'h508;
  localparam logic [11:0] OFF_OUTCLR = 12'h50C;
  localparam logic [11:0] OFF_IN = 12'h510;
  localparam logic [11:0] OFF_DIR = 12'h514;
  localparam logic [11:0] OFF_DIRSET = 12'h518;
  localparam logic [11:0] OFF_DIRCLR = 12'h51C;
  localparam logic [11:0] OFF_LATCH = 12'h520;
  localparam logic [11:0] OFF_MODE = 12'h524;
  localparam logic [11:0] OFF_CFG_BASE = 12'h700;
  localparam logic [11:0] OFF_CFG_LAST = 12'h77C;
  // pin_config field positions
  localparam int CFG_DIR_POS = 0;
  localparam int CFG_INBUF_POS = 1;
  localparam int CFG_PULL_POS = 2;
  localparam int CFG_DRIVE_POS = 8;
  localparam int CFG_SENSE_POS = 16;
  // reset values and writable bits
  localparam logic [31:0] CFG_RESET = 32'h0000_0002;
  localparam logic [31:0] CFG_STORE_MASK = 32'h0003_070E;
  localparam logic [31:0] PORT_RESET = 32'h0000_0000;
  // field encodings
  localparam logic [1:0] SENSE_OFF = 2'h0;
  localparam logic [1:0] SENSE_HIGH = 2'h2;
  localparam logic [1:0] SENSE_LOW = 2'h3;
  localparam logic [1:0] PULL_DOWN = 2'h1;
  localparam logic [1:0] PULL_UP = 2'h3;
  localparam logic INBUF_CONNECT = 1'h0;
  localparam logic MODE_COMBINED = 1'h0;
  localparam logic MODE_LATCHED = 1'h1;
  // bus slave sequencing
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_FETCH = 3'b010,
    BUS_ACK = 3'b100
  } bus_state_t;
  // byte enables widened to a bit mask
  function automatic logic [31:0] byte_mask(input logic [3:0] sel);
    return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction
  // level sense match for one pin
  function automatic logic sense_hit(input logic [1:0] sense, input logic lvl);
    return ((sense == SENSE_HIGH) & lvl) | ((sense == SENSE_LOW) & ~lvl);
  endfunction
  // drive mode to {enable, high strength} for the level driven
  function automatic logic [1:0] drive_ctl(input logic [2:0] drv, input logic lvl);
    logic oe;
    logic hi;
    oe = 1'b1;
    hi = 1'b0;
    case (drv)
      3'h1: hi = ~lvl;
      3'h2: hi = lvl;
      3'h3: hi = 1'b1;
      3'h4: oe = lvl;
      3'h5: begin
        oe = lvl;
        hi = 1'b1;
      end
      3'h6: oe = ~lvl;
      3'h7: begin
        oe = ~lvl;
        hi = 1'b1;
      end
      default: hi = 1'b0;
    endcase
    return {oe, hi & oe};
  endfunction
endpackage

// ===== hw/pin_config_store.sv
// retained pin_config words with parallel fields and registered read
`timescale 1ns/1ns
module pin_config_store (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic we_i,
  input wire logic [4:0] widx_i,
  input wire logic [31:0] wdata_i,
  input wire logic [31:0] wmask_i,
  input wire logic [4:0] ridx_i,
  output logic [31:0] rdata_o,
  output logic [31:0][31:0] cfg_o
);
  logic [31:0][31:0] mem; // one word per pin
  logic [31:0] m; // bits this write may change
  assign m = wmask_i & gpio_pkg::CFG_STORE_MASK;
  assign cfg_o = mem;
  // only power-on reset clears it, so contents survive warm resets
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < gpio_pkg::NPINS; i++) begin
        mem[i] <= gpio_pkg::CFG_RESET;
      end
      rdata_o <= 32'h0000_0000;
    end else if (ce_i) begin
      if (we_i) begin
        mem[widx_i] <= (mem[widx_i] & ~m) | (wdata_i & m);
      end
      rdata_o <= mem[ridx_i];
    end
  end
endmodule

// ===== hw/pin_sync.sv
// three-stage pin input synchroniser with agreement filter
`timescale 1ns/1ns
module pin_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [31:0] async_i,
  output logic [31:0] sync_o
);
  logic [31:0] s1; // metastable catch, read by s2 only
  logic [31:0] s2;
  logic [31:0] s3;
  logic [31:0] next_sync;
  // a change counts once stages two and three agree
  assign next_sync = (s2 & s3) | (sync_o & (s2 ^ s3));
  // shift chain, frozen with the clock enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1 <= 32'h0000_0000;
      s2 <= 32'h0000_0000;
      s3 <= 32'h0000_0000;
      sync_o <= 32'h0000_0000;
    end else if (ce_i) begin
      s1 <= async_i;
      s2 <= s1;
      s3 <= s2;
      sync_o <= next_sync;
    end
  end
endmodule

// ===== verification/gpio_level_sense_latch_tb_top.sv
// self-checking bench of the level sense pin port
`timescale 1ns/1ns
module gpio_level_sense_latch_tb_top;
  logic clk, rst, warm_rst, ce, sleep, we, cyc, stb, ack, ldet, ldet_q, pdet, pev;
  logic [11:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q, e, pin_in, pin_out, pin_oe, hdrv, pu, pd, ibuf;
  logic [31:0] psel, pout, poe, pin_rd, tset, tclr, det, ext_en, ext_val;
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;
  int ev_cnt = 0;
  int ld_rise = 0;
  int seed, k, j, r0;
  // free-running clock, 40 ns period
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  gpio_level_sense_latch dut (.clk_i(clk), .rst_i(rst), .warm_rst_i(warm_rst), .ce_i(ce),
    .sleep_i(sleep), .adr_i(adr), .dat_i(wdat), .sel_i(sel), .we_i(we), .cyc_i(cyc),
    .stb_i(stb), .dat_o(rdat), .ack_o(ack), .pin_i(pin_in), .pin_o(pin_out),
    .pin_oe_o(pin_oe), .high_drive_o(hdrv), .pull_up_o(pu), .pull_down_o(pd),
    .in_buf_en_o(ibuf), .periph_sel_i(psel), .periph_out_i(pout), .periph_oe_i(poe),
    .periph_in_o(pin_rd), .te_set_i(tset), .te_clr_i(tclr), .per_pin_detect_o(det),
    .latched_detect_o(ldet), .port_detect_o(pdet), .port_event_o(pev));
  pin_partner far (.clk_i(clk), .ext_en_i(ext_en), .ext_val_i(ext_val), .drv_i(pin_out),
    .oe_i(pin_oe), .pull_up_i(pu), .pull_down_i(pd), .level_o(pin_in));
  // event and rising-edge counters, plus the hang limit
  always @(posedge clk) begin
    cycles <= cycles + 1;
    ldet_q <= ldet;
    if (pev === 1'b1) begin
      ev_cnt <= ev_cnt + 1;
    end
    if (ldet === 1'b1 && ldet_q === 1'b0) begin
      ld_rise <= ld_rise + 1;
    end
    if (cycles == 6000) begin
      fails = fails + 1;
      final_report();
    end
  end
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] want, input string what);
    n_compared++;
    if (got !== want) begin
      fails++;
      $display("BAD %0t %s got %h want %h", $time, what, got, want);
    end
  endtask
  // one classic cycle; waits for ack, which may take any number of cycles
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
    // ack must stand for one cycle only
    check({31'h0000_0000, ack}, 32'h0000_0000, "ack one cycle");
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] want, input string what);
    wb(1'b0, a, 32'h0000_0000);
    check(q, want, what);
  endtask
  // outside drive, then long enough for sync, detect, latch and port detect
  task automatic pins(input logic [31:0] v);
    ext_val <= v;
    repeat (8) @(posedge clk);
  endtask
  function automatic logic [11:0] caddr(input int n);
    return gpio_pkg::OFF_CFG_BASE + 12'(n * 4);
  endfunction
  function automatic logic [31:0] sw(input logic [1:0] s, input logic ib);
    return (32'(s) << gpio_pkg::CFG_SENSE_POS) | (32'(ib) << gpio_pkg::CFG_INBUF_POS);
  endfunction
  function automatic logic [31:0] oh(input int n);
    return 32'h0000_0001 << n;
  endfunction
  initial begin
    seed = 39;
    {rst, warm_rst, ce, sleep, we, cyc, stb} = 7'b1010000;
    {adr, wdat, sel} = {12'h000, 32'h0000_0000, 4'hF};
    {psel, pout, poe, tset, tclr} = {160{1'b0}};
    ext_en = 32'hFFFF_FFFF;
    ext_val = 32'h0000_0000;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    k = {$random(seed)} % 32;
    j = (k + 1) % 32;
    // reset values and an unmapped hole
    rd(caddr(k), gpio_pkg::CFG_RESET, "cfg reset");
    rd(gpio_pkg::OFF_MODE, 32'h0000_0000, "mode reset");
    rd(gpio_pkg::OFF_LATCH, 32'h0000_0000, "latch reset");
    rd(12'h600, 32'h0000_0000, "unmapped");
    // connect every input buffer, sensing off
    for (int n = 0; n < 32; n++) begin
      wb(1'b1, caddr(n), 32'h0000_0000);
    end
    rd(caddr(31), 32'h0000_0000, "cfg last");
    check(ibuf, 32'hFFFF_FFFF, "inbuf on");
    e = $random(seed);
    pins(e);
    rd(gpio_pkg::OFF_IN, e, "in");
    check(pin_rd, e, "periph in");
    // disconnected buffer hides the pin from sense and input
    pins(32'hFFFF_FFFF);
    wb(1'b1, caddr(k), sw(gpio_pkg::SENSE_HIGH, 1'b1));
    repeat (8) @(posedge clk);
    check(det, 32'h0000_0000, "det disc");
    rd(gpio_pkg::OFF_IN, ~oh(k), "in disc");
    // a cut-off pin reads low, yet low sense must not fire
    wb(1'b1, caddr(k), sw(gpio_pkg::SENSE_LOW, 1'b1));
    repeat (8) @(posedge clk);
    check(det, 32'h0000_0000, "det disc low");
    // condition already true when sensing turns on
    r0 = ev_cnt;
    wb(1'b1, caddr(k), sw(gpio_pkg::SENSE_HIGH, 1'b0));
    repeat (8) @(posedge clk);
    check(det, oh(k), "det on enable");
    check({31'h0, pdet}, 32'h0000_0001, "port det");
    check(32'(ev_cnt - r0), 32'h0000_0001, "port event");
    rd(gpio_pkg::OFF_LATCH, oh(k), "latch set");
    check({31'h0, ldet}, 32'h0000_0001, "ldet");
    // clear attempt while the pin still matches
    wb(1'b1, gpio_pkg::OFF_LATCH, oh(k));
    rd(gpio_pkg::OFF_LATCH, oh(k), "latch kept");
    pins(~oh(k));
    check(det, 32'h0000_0000, "det fall");
    check({31'h0, pdet}, 32'h0000_0000, "port det fall");
    rd(gpio_pkg::OFF_LATCH, oh(k), "latch sticky");
    wb(1'b1, gpio_pkg::OFF_LATCH, oh(k));
    rd(gpio_pkg::OFF_LATCH, 32'h0000_0000, "latch clear");
    repeat (4) @(posedge clk);
    check({31'h0, ldet}, 32'h0000_0000, "ldet low");
    // low sense on pin j, parked high before enabling
    wb(1'b1, caddr(j), sw(gpio_pkg::SENSE_LOW, 1'b0));
    repeat (8) @(posedge clk);
    check(det, 32'h0000_0000, "low parked");
    pins(~(oh(k) | oh(j)));
    check(det, oh(j), "low sense");
    // latched source keeps the port detect up after the pin lets go
    wb(1'b1, gpio_pkg::OFF_MODE, 32'h0000_0001);
    rd(gpio_pkg::OFF_MODE, 32'h0000_0001, "mode");
    pins(~oh(k));
    check({31'h0, pdet}, 32'h0000_0001, "latched port det");
    pins(32'hFFFF_FFFF);
    pins(~oh(k));
    r0 = ld_rise;
    wb(1'b1, gpio_pkg::OFF_LATCH, oh(j));
    repeat (4) @(posedge clk);
    check(32'(ld_rise - r0), 32'h0000_0001, "ldet new edge");
    rd(gpio_pkg::OFF_LATCH, oh(k), "latch partial");
    wb(1'b1, gpio_pkg::OFF_LATCH, oh(k));
    repeat (4) @(posedge clk);
    check({30'h0, ldet, pdet}, 32'h0000_0000, "all clear");
    wb(1'b1, gpio_pkg::OFF_MODE, 32'h0000_0000);
    // sensing keeps running in deep sleep
    // clock enable low freezes the input path, so the change is not seen
    ce <= 1'b0;
    pins(32'hFFFF_FFFF);
    check(det, 32'h0000_0000, "ce frozen");
    ce <= 1'b1;
    sleep <= 1'b1;
    pins(32'hFFFF_FFFF);
    check(det, oh(k), "sleep det");
    check({31'h0, pdet}, 32'h0000_0001, "sleep port det");
    sleep <= 1'b0;
    // outputs, task interconnect and takeover
    wb(1'b1, gpio_pkg::OFF_DIR, 32'hFFFF_FFFF);
    e = $random(seed);
    wb(1'b1, gpio_pkg::OFF_OUT, e);
    repeat (3) @(posedge clk);
    check(pin_out, e, "out");
    check(pin_oe, 32'hFFFF_FFFF, "oe");
    // pin j: output, pull up, high drive both levels
    wb(1'b1, caddr(j), (32'(gpio_pkg::PULL_UP) << gpio_pkg::CFG_PULL_POS)
      | (32'h0000_0003 << gpio_pkg::CFG_DRIVE_POS) | 32'h0000_0001);
    repeat (2) @(posedge clk);
    check(pu, oh(j), "pull up");
    check(pd, 32'h0000_0000, "no pull down");
    check(hdrv, oh(j), "high drive");
    tset <= oh(j);
    tclr <= oh(j);
    @(posedge clk);
    tset <= 32'h0000_0000;
    tclr <= 32'h0000_0000;
    repeat (3) @(posedge clk);
    check(pin_out, e | oh(j), "task set");
    tclr <= oh(j);
    @(posedge clk);
    tclr <= 32'h0000_0000;
    repeat (3) @(posedge clk);
    e = e & ~oh(j);
    check(pin_out, e, "task clr");
    psel <= oh(k);
    pout <= ~e;
    poe <= 32'hFFFF_FFFF;
    repeat (4) @(posedge clk);
    check(pin_out, (e & ~oh(k)) | (~e & oh(k)), "takeover");
    psel <= 32'h0000_0000;
    // warm reset keeps the config words and direction
    warm_rst <= 1'b1;
    @(posedge clk);
    warm_rst <= 1'b0;
    @(posedge clk);
    rd(caddr(k), sw(gpio_pkg::SENSE_HIGH, 1'b0) | 32'h0000_0001, "retained");
    rd(gpio_pkg::OFF_DIR, 32'hFFFF_FFFF, "dir kept");
    final_report();
  end
endmodule

// ===== verification/pin_partner.sv
// far-side model of the pins: external drivers, pulls, floating lines
`timescale 1ns/1ns
module pin_partner (
  input wire logic clk_i,
  input wire logic [31:0] ext_en_i,
  input wire logic [31:0] ext_val_i,
  input wire logic [31:0] drv_i,
  input wire logic [31:0] oe_i,
  input wire logic [31:0] pull_up_i,
  input wire logic [31:0] pull_down_i,
  output logic [31:0] level_o
);
  // pattern for an undriven, unpulled line; it never holds a stale level
  logic [31:0] flt = 32'h5555_5555;
  // toggles every cycle so a floating pin cannot pass for a steady value
  always @(posedge clk_i) begin
    flt <= ~flt;
  end
  // port driver wins, then the outside driver, then the pulls
  assign level_o = (oe_i & drv_i) | (~oe_i & ext_en_i & ext_val_i)
    | (~oe_i & ~ext_en_i & (pull_up_i | (~pull_down_i & flt)));
endmodule
